/* mac_wake_pause.sv */
/*
  receive and transmit control of an ethernet mac: magic packet wake
  detection and full duplex pause flow control. assumes receive bytes,
  fifo levels and the byte-time tick all come from logic on clock_i.
*/
// The strobed register port and the register addresses were decided locally.
// Function
// - in wake mode, scan the received byte stream for magic packets
// - in wake mode drop every received frame, withhold transmit requests
// - magic packet: own station address repeated sixteen times in a row
// - a detected magic packet raises the wake interrupt output
// - wake frame destination must be own address or broadcast
// - pause frame is sixty bytes long without the fcs
// - type 8808, opcode 0001, timer value, then 42 zero bytes
// - pause accepted for reserved multicast or own; sent to multicast
// - timer is 16 bits, high octet first, in 512 bit-time quanta
// - software-built pause frames pass through like ordinary frames
// - generated pause uses station address and programmed timer value
// - automatic pause only in full duplex with flow control enabled
// - new frame with vacant entries below high mark sends a pause
// - falling to low mark sends one zero pause after a nonzero one
// - pause accept enable governs storing received timer values
// - only error-free pause frames act, at end of reception
// - pause during a frame lets it finish, then holds queued frames
// - control frames reach dma only when pass pause frames is set
// - pause state counts down; each new pause reloads the timer
// - received pause blocks only regular frames, not own pauses
`timescale 1ns/1ns
`default_nettype none
`include "mac_wake_pause_defines.svh"

module mac_wake_pause
#(
	parameter int FIFO_AW = 11
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_sof_i,
	input wire logic rx_eof_i,
	input wire logic rx_err_i,
	input wire logic [FIFO_AW-1:0] fifo_vacant_i,
	input wire logic [FIFO_AW-1:0] fifo_used_i,
	input wire logic byte_tick_i,
	output logic dma_valid_o,
	output logic [7:0] dma_data_o,
	output logic dma_sof_o,
	output logic dma_eof_o,
	output logic dma_discard_o,
	input wire logic tx_pending_i,
	input wire logic tx_busy_i,
	output logic tx_allow_o,
	output logic gen_valid_o,
	output logic [7:0] gen_data_o,
	output logic gen_sof_o,
	output logic gen_eof_o,
	input wire logic gen_ready_i,
	output logic wake_irq_o,
	output logic paused_o
);
	import mac_wake_pause_pkg::*;

	// ----------------------------------------
	// elaboration check
	// ----------------------------------------
	if (FIFO_AW < 1 || FIFO_AW > 16)
	begin : g_bad_width
		$error("FIFO_AW must lie between 1 and 16");
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] addr_byte(input logic [47:0] a,
		input logic [2:0] i);
		logic [47:0] t;
		t = a << ({3'h0, i} * 6'h08);
		return t[47:40];
	endfunction

	function automatic logic [7:0] pause_byte(input logic [5:0] i,
		input logic [47:0] sa, input logic [15:0] tv);
		logic [7:0] b;
		b = 8'h00;
		if (i < 6'(`ADDR_BYTES))
			b = addr_byte(`RESERVED_DA, i[2:0]);
		else if (i < 6'(2 * `ADDR_BYTES))
			b = addr_byte(sa, 3'(i - 6'(`ADDR_BYTES)));
		else if (i == 6'(`IDX_TYPE))
			b = `CTL_TYPE_HI;
		else if (i == 6'(`IDX_TYPE + 1))
			b = `CTL_TYPE_LO;
		else if (i == 6'(`IDX_OP))
			b = `PAUSE_OP_HI;
		else if (i == 6'(`IDX_OP + 1))
			b = `PAUSE_OP_LO;
		else if (i == 6'(`IDX_TIMER))
			b = tv[15:8];
		else if (i == 6'(`IDX_TIMER + 1))
			b = tv[7:0];
		return b;
	endfunction

	state_t s;
	state_t next_s;

	logic [47:0] station;
	logic [10:0] idx;
	logic wake;
	logic rx_en;
	logic auto_fc;
	logic own_b;
	logic resv_b;
	logic first;
	logic magic_hit;
	logic pause_ok;
	logic zero_armed;
	logic [15:0] vacant;
	logic [15:0] used;

	assign station = {s.addr_high, s.addr_low};
	assign wake = s.mode[`MODE_WAKE];
	assign rx_en = s.mode[`MODE_RX_EN];
	assign auto_fc = s.mode[`MODE_AUTO_FC] & s.mode[`MODE_FDX];
	assign vacant = 16'(fifo_vacant_i);
	assign used = 16'(fifo_used_i);
	assign zero_armed = s.sent_nonzero;

	always_comb
	begin
		next_s = s;
		first = rx_sof_i;
		idx = first ? 11'h000 : s.byte_cnt;
		own_b = 1'b0;
		resv_b = 1'b0;
		magic_hit = 1'b0;
		pause_ok = 1'b0;
		next_s.dma_valid = 1'b0;
		next_s.dma_sof = 1'b0;
		next_s.dma_eof = 1'b0;
		next_s.dma_discard = 1'b0;
		next_s.wake_pulse = 1'b0;

		// ----------------------------------------
		// register port
		// ----------------------------------------
		next_s.rdata = 32'h00000000;
		if (rd_i)
		begin
			unique case (addr_i)
				`OFS_MODE:
					next_s.rdata = {25'h0000000, s.rx_st == RX_IDLE,
						s.mode};
				`OFS_ADDR_HIGH:
					next_s.rdata = {16'h0000, s.addr_high};
				`OFS_ADDR_LOW:
					next_s.rdata = s.addr_low;
				`OFS_PAUSE_TIMER:
					next_s.rdata = {16'h0000, s.pause_val};
				`OFS_WATERMARK:
					next_s.rdata = {s.mark_high, s.mark_low};
				`OFS_STATUS:
					next_s.rdata = {s.pause_cnt, 13'h0000, zero_armed,
						s.wake_seen, s.pause_cnt != 16'h0000};
				default:
					next_s.rdata = 32'h00000000;
			endcase
		end
		if (wr_i)
		begin
			unique case (addr_i)
				`OFS_MODE:
					next_s.mode = wdata_i[`MODE_WIDTH-1:0];
				`OFS_ADDR_HIGH:
					next_s.addr_high = wdata_i[15:0];
				`OFS_ADDR_LOW:
					next_s.addr_low = wdata_i;
				`OFS_PAUSE_TIMER:
					next_s.pause_val = wdata_i[15:0];
				`OFS_WATERMARK:
				begin
					next_s.mark_low = wdata_i[15:0];
					next_s.mark_high = wdata_i[31:16];
				end
				`OFS_STATUS:
					// write one clears; a new detection below wins
					if (wdata_i[`STAT_WAKE])
						next_s.wake_seen = 1'b0;
				default:
				begin
				end
			endcase
		end

		// ----------------------------------------
		// receive parsing
		// ----------------------------------------
		if (rx_valid_i && rx_en && (first || s.rx_st == RX_FRAME))
		begin
			next_s.rx_st = rx_eof_i ? RX_IDLE : RX_FRAME;
			if (idx != 11'h7FF)
				next_s.byte_cnt = idx + 11'h001;
			if (idx < 11'(`ADDR_BYTES))
			begin
				own_b = rx_data_i == addr_byte(station, idx[2:0]);
				resv_b = rx_data_i == addr_byte(`RESERVED_DA, idx[2:0]);
				next_s.da_own = (first | s.da_own) & own_b;
				next_s.da_bcast = (first | s.da_bcast) &
					(rx_data_i == `BCAST_BYTE);
				next_s.da_resv = (first | s.da_resv) & resv_b;
			end
			if (idx == 11'(`IDX_TYPE))
				next_s.ctl_type = rx_data_i == `CTL_TYPE_HI;
			if (idx == 11'(`IDX_TYPE + 1))
				next_s.ctl_type = s.ctl_type &
					(rx_data_i == `CTL_TYPE_LO);
			if (idx == 11'(`IDX_OP))
				next_s.pause_op = rx_data_i == `PAUSE_OP_HI;
			if (idx == 11'(`IDX_OP + 1))
				next_s.pause_op = s.pause_op &
					(rx_data_i == `PAUSE_OP_LO);
			if (idx == 11'(`IDX_TIMER))
				next_s.rx_timer[15:8] = rx_data_i;
			if (idx == 11'(`IDX_TIMER + 1))
				next_s.rx_timer[7:0] = rx_data_i;

			if (first || idx < 11'(`IDX_OP))
			begin
				next_s.mpos = 3'h0;
				next_s.mrep = 5'h00;
			end
			else if (s.mrep != 5'(`MAGIC_REPEATS))
			begin
				if (rx_data_i == addr_byte(station, s.mpos))
				begin
					if (s.mpos == 3'(`ADDR_BYTES - 1))
					begin
						next_s.mpos = 3'h0;
						next_s.mrep = s.mrep + 5'h01;
					end
					else
						next_s.mpos = s.mpos + 3'h1;
				end
				else
				begin
					// restart, this byte may open a new copy
					next_s.mrep = 5'h00;
					next_s.mpos = (rx_data_i == addr_byte(station, 3'h0))
						? 3'h1 : 3'h0;
				end
			end

			if (!wake)
			begin
				next_s.dma_valid = 1'b1;
				next_s.dma_data = rx_data_i;
				next_s.dma_sof = first;
				next_s.dma_eof = rx_eof_i;
			end

			if (rx_eof_i)
			begin
				magic_hit = wake && !rx_err_i &&
					next_s.mrep == 5'(`MAGIC_REPEATS) &&
					(next_s.da_own || next_s.da_bcast);
				// act only on a clean finished frame
				pause_ok = !rx_err_i && next_s.ctl_type &&
					next_s.pause_op && idx + 11'h001 >=
					11'(`PAUSE_FRAME_BYTES) &&
					(next_s.da_resv || next_s.da_own);
				next_s.dma_discard = !wake && (rx_err_i ||
					(next_s.ctl_type && !s.mode[`MODE_PASS]));
			end
		end
		else if (!rx_en)
			next_s.rx_st = RX_IDLE;

		if (magic_hit)
		begin
			next_s.wake_pulse = 1'b1;
			next_s.wake_seen = 1'b1;
		end

		// ----------------------------------------
		// pause timer
		// ----------------------------------------
		if (byte_tick_i && s.pause_cnt != 16'h0000)
		begin
			// one count per 512 bit times
			if (s.quantum == 6'(`QUANTUM_BYTES - 1))
			begin
				next_s.quantum = 6'h00;
				next_s.pause_cnt = s.pause_cnt - 16'h0001;
			end
			else
				next_s.quantum = s.quantum + 6'h01;
		end
		if (pause_ok && s.mode[`MODE_ACCEPT] && s.mode[`MODE_FDX])
		begin
			next_s.pause_cnt = next_s.rx_timer;
			next_s.quantum = 6'h00;
		end

		// ----------------------------------------
		// automatic pause requests
		// ----------------------------------------
		// new frame meets high mark
		if (auto_fc && rx_valid_i && rx_en && first && !wake &&
			vacant < s.mark_high)
			next_s.req_on = 1'b1;
		// one zero pause after a nonzero one
		if (auto_fc && s.sent_nonzero && used <= s.mark_low &&
			!s.req_on)
		begin
			next_s.req_zero = 1'b1;
			next_s.sent_nonzero = 1'b0;
		end
		if (!auto_fc)
		begin
			next_s.req_on = 1'b0;
			next_s.req_zero = 1'b0;
		end

		// ----------------------------------------
		// pause frame generator
		// ----------------------------------------
		unique case (s.gen_st)
			GEN_IDLE:
				// never cut into a frame on the wire
				if ((s.req_on || s.req_zero) && !tx_busy_i && !wake)
				begin
					next_s.gen_st = GEN_SEND;
					next_s.gen_idx = 6'h00;
					// programmed timer value, zero for release
					next_s.gen_timer = s.req_on ? s.pause_val : 16'h0000;
					if (s.req_on)
					begin
						next_s.req_on = 1'b0;
						next_s.sent_nonzero = s.pause_val != 16'h0000;
					end
					else
						next_s.req_zero = 1'b0;
					next_s.gen_valid = 1'b1;
					next_s.gen_sof = 1'b1;
					next_s.gen_eof = 1'b0;
					next_s.gen_data = pause_byte(6'h00, station,
						next_s.gen_timer);
				end
			GEN_SEND:
				if (gen_ready_i)
				begin
					if (s.gen_idx == 6'(`PAUSE_FRAME_BYTES - 1))
					begin
						next_s.gen_st = GEN_IDLE;
						next_s.gen_valid = 1'b0;
						next_s.gen_eof = 1'b0;
						next_s.gen_sof = 1'b0;
					end
					else
					begin
						next_s.gen_idx = s.gen_idx + 6'h01;
						next_s.gen_sof = 1'b0;
						next_s.gen_eof = next_s.gen_idx ==
							6'(`PAUSE_FRAME_BYTES - 1);
						next_s.gen_data = pause_byte(next_s.gen_idx,
							station, s.gen_timer);
					end
				end
		endcase
		// a request raised in the cycle the idle generator takes the pending one stays pending
		if (auto_fc && rx_valid_i && rx_en && first && !wake &&
			vacant < s.mark_high && s.gen_st == GEN_IDLE &&
			!tx_busy_i && s.req_on)
			next_s.req_on = 1'b1;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			next_state_reset();
		else if (ce_i)
			s <= next_s;
	end

	task automatic next_state_reset();
		s <= '0;
	endtask

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// no transmit requests in wake mode
	assign tx_allow_o = !wake && s.pause_cnt == 16'h0000 &&
		s.gen_st == GEN_IDLE && !s.req_on && !s.req_zero &&
		tx_pending_i;
	assign rdata_o = s.rdata;
	assign dma_valid_o = s.dma_valid;
	assign dma_data_o = s.dma_data;
	assign dma_sof_o = s.dma_sof;
	assign dma_eof_o = s.dma_eof;
	assign dma_discard_o = s.dma_discard;
	// software pause frames take the regular path untouched
	assign gen_valid_o = s.gen_valid;
	assign gen_data_o = s.gen_data;
	assign gen_sof_o = s.gen_sof;
	assign gen_eof_o = s.gen_eof;
	assign wake_irq_o = s.wake_pulse;
	assign paused_o = s.pause_cnt != 16'h0000;

endmodule
`default_nettype wire

/* mac_wake_pause_defines.svh */
/*
  register offsets, field positions, frame constants and timing figures
  for the wake and pause flow control block. assumes inclusion by bare name.
*/
`ifndef MAC_WAKE_PAUSE_DEFINES_SVH
`define MAC_WAKE_PAUSE_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_MODE 8'h00
`define OFS_ADDR_HIGH 8'h04
`define OFS_ADDR_LOW 8'h08
`define OFS_PAUSE_TIMER 8'h0C
`define OFS_WATERMARK 8'h10
`define OFS_STATUS 8'h14

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define MODE_WIDTH 6
`define MODE_WAKE 0
`define MODE_RX_EN 1
`define MODE_FDX 2
`define MODE_AUTO_FC 3
`define MODE_ACCEPT 4
`define MODE_PASS 5
`define MODE_RX_IDLE 6

// ----------------------------------------
// status register fields
// ----------------------------------------
`define STAT_PAUSED 0
`define STAT_WAKE 1
`define STAT_ZERO_ARMED 2
`define STAT_COUNT_LSB 16

// ----------------------------------------
// frame figures
// ----------------------------------------
`define CTL_TYPE_HI 8'h88
`define CTL_TYPE_LO 8'h08
`define PAUSE_OP_HI 8'h00
`define PAUSE_OP_LO 8'h01
`define BCAST_BYTE 8'hFF
`define RESERVED_DA 48'h0180C2000001
`define PAUSE_FRAME_BYTES 60
`define MAGIC_REPEATS 16
`define ADDR_BYTES 6
`define IDX_TYPE 12
`define IDX_OP 14
`define IDX_TIMER 16
`define QUANTUM_BITS 512
`define BYTE_BITS 8
`define QUANTUM_BYTES (`QUANTUM_BITS / `BYTE_BITS)

`endif

/* mac_wake_pause_pkg.sv */
/*
  types for the wake and pause flow control block.
  assumes nothing beyond a systemverilog compiler.
*/
package mac_wake_pause_pkg;

	typedef enum logic
	{
		RX_IDLE = 1'b0,
		RX_FRAME = 1'b1
	} rx_state_t;

	typedef enum logic
	{
		GEN_IDLE = 1'b0,
		GEN_SEND = 1'b1
	} gen_state_t;

	typedef struct packed
	{
		rx_state_t rx_st;
		logic [10:0] byte_cnt;
		logic da_own;
		logic da_bcast;
		logic da_resv;
		logic ctl_type;
		logic pause_op;
		logic [15:0] rx_timer;
		logic [2:0] mpos;
		logic [4:0] mrep;
		logic dma_valid;
		logic [7:0] dma_data;
		logic dma_sof;
		logic dma_eof;
		logic dma_discard;
		logic wake_pulse;
		logic wake_seen;
		logic [5:0] mode;
		logic [15:0] addr_high;
		logic [31:0] addr_low;
		logic [15:0] pause_val;
		logic [15:0] mark_low;
		logic [15:0] mark_high;
		logic [31:0] rdata;
		logic [15:0] pause_cnt;
		logic [5:0] quantum;
		logic req_on;
		logic req_zero;
		logic sent_nonzero;
		gen_state_t gen_st;
		logic [5:0] gen_idx;
		logic [15:0] gen_timer;
		logic gen_valid;
		logic [7:0] gen_data;
		logic gen_sof;
		logic gen_eof;
	} state_t;

endpackage

/* mac_wake_pause_monitor.sv */
/*
  concurrent checks on the ports of mac_wake_pause.
  assumes ce_i high whenever frames move, mode writes while receive is quiet.
*/
`timescale 1ns/1ns
`default_nettype none
module mac_wake_pause_monitor
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rx_valid_i,
	input wire logic rx_eof_i,
	input wire logic dma_valid_o,
	input wire logic dma_eof_o,
	input wire logic dma_discard_o,
	input wire logic tx_allow_o,
	input wire logic gen_valid_o,
	input wire logic [7:0] gen_data_o,
	input wire logic gen_sof_o,
	input wire logic gen_eof_o,
	input wire logic gen_ready_i,
	input wire logic wake_irq_o,
	input wire logic paused_o
);
	logic [5:0] mode_m;
	logic [6:0] gcnt;

	// ----------------------------------------
	// shadow of mode and generator byte index
	// ----------------------------------------
	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			mode_m <= 6'h00;
			gcnt <= 7'h00;
		end
		else
		begin
			if (wr_i && addr_i == 8'h00)
				mode_m <= wdata_i[5:0];
			if (gen_valid_o && gen_ready_i)
				gcnt <= gen_eof_o ? 7'h00 : gcnt + 7'h01;
		end

	default clocking @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	// ----------------------------------------
	// properties
	// ----------------------------------------
	AST_WAKE_NO_DMA: assert property (
		mode_m[0] && $past(mode_m[0]) |-> !dma_valid_o)
		else $error("frame forwarded in wake mode");
	AST_WAKE_NO_TX: assert property (
		mode_m[0] |-> !tx_allow_o)
		else $error("transmit allowed in wake mode");
	AST_IRQ_CAUSE: assert property (
		wake_irq_o |-> $past(rx_eof_i && rx_valid_i) ##1 !wake_irq_o)
		else $error("wake pulse without frame end");
	AST_GEN_LEN: assert property (
		gen_valid_o && gen_eof_o |-> gcnt == 7'h3B)
		else $error("pause frame length wrong");
	AST_GEN_DA: assert property (
		gen_valid_o && gen_sof_o |-> gen_data_o == 8'h01 && gcnt == 7'h00)
		else $error("pause frame first byte wrong");
	AST_GEN_TYPE: assert property (
		gen_valid_o && (gcnt == 7'h0C || gcnt == 7'h0D)
		|-> gen_data_o == (gcnt == 7'h0C ? 8'h88 : 8'h08))
		else $error("control type wrong");
	AST_GEN_PAD: assert property (
		gen_valid_o && gcnt >= 7'h12 |-> gen_data_o == 8'h00)
		else $error("pause padding not zero");
	AST_AUTO_ONLY: assert property (
		$rose(gen_valid_o) |-> mode_m[2] && mode_m[3])
		else $error("pause generated without full duplex flow control");
	AST_PAUSE_BLOCK: assert property (
		paused_o |-> !tx_allow_o)
		else $error("regular frame allowed while paused");
	AST_PAUSE_START: assert property (
		$rose(paused_o) |-> $past(rx_eof_i && rx_valid_i))
		else $error("pause began before frame end");
	AST_DISCARD_EOF: assert property (
		dma_discard_o |-> dma_eof_o && dma_valid_o)
		else $error("discard away from frame end");
endmodule

bind mac_wake_pause mac_wake_pause_monitor mon
(
	.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rx_valid_i, .rx_eof_i,
	.dma_valid_o, .dma_eof_o, .dma_discard_o, .tx_allow_o, .gen_valid_o,
	.gen_data_o, .gen_sof_o, .gen_eof_o, .gen_ready_i, .wake_irq_o,
	.paused_o
);
`default_nettype wire

/* mac_link_partner.sv */
/*
  link partner model: plays receive frames byte by byte and takes the
  generated pause stream with irregular stalls. assumes one clock.
*/
`timescale 1ns/1ns
`default_nettype none
module mac_link_partner
(
	input wire logic clock_i,
	input wire logic gen_valid_i,
	input wire logic [7:0] gen_data_i,
	output logic gen_ready_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_sof_o,
	output logic rx_eof_o,
	output logic rx_err_o
);
	logic [7:0] fr [0:127];
	logic [7:0] cap [0:127];
	logic [7:0] lf;
	int ccount;

	initial
	begin
		{rx_valid_o, rx_sof_o, rx_eof_o, rx_err_o, gen_ready_o} = 5'h00;
		rx_data_o = 8'h00;
		lf = 8'h5A;
		ccount = 0;
	end

	// stalls roughly one byte in four, like a busy transmitter
	always @(posedge clock_i)
	begin
		lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		gen_ready_o <= lf[0] | lf[1];
		if (gen_valid_i && gen_ready_o)
		begin
			cap[ccount] <= gen_data_i;
			ccount <= ccount + 1;
		end
	end

	task automatic send(input int n, input logic e);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clock_i);
			rx_valid_o <= 1'b1;
			rx_data_o <= fr[i];
			rx_sof_o <= (i == 0);
			rx_eof_o <= (i == n - 1);
			rx_err_o <= e && (i == n - 1);
		end
		@(posedge clock_i);
		{rx_valid_o, rx_sof_o, rx_eof_o, rx_err_o} <= 4'h0;
		// idle data is the inverted last byte so nothing reads a stale byte
		rx_data_o <= ~rx_data_o;
	endtask
endmodule
`default_nettype wire

/* tb_mac_wake_pause.sv */
/*
  self-checking bench for mac_wake_pause with a link partner model.
  assumes the monitor is bound by its own file.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_mac_wake_pause;
	logic clock_i, rst_i, wr_i, rd_i, rx_valid_i, rx_sof_i, rx_eof_i;
	logic rx_err_i, byte_tick_i, tx_pending_i, tx_busy_i, gen_ready_i;
	logic [7:0] addr_i, rx_data_i, dma_data_o, gen_data_o;
	logic [31:0] wdata_i, rdata_o, seed;
	logic [10:0] fifo_vacant_i, fifo_used_i;
	logic dma_valid_o, dma_sof_o, dma_eof_o, dma_discard_o, tx_allow_o;
	logic gen_valid_o, gen_sof_o, gen_eof_o, wake_irq_o, paused_o;
	logic [47:0] sa;
	logic [15:0] tv;
	logic [7:0] dsof;
	logic ce_i;
	int mismatches, comparisons, irq_n, disc_n, dv_n, dv0, eof_n;

	mac_wake_pause dut
	(
		.clock_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .rx_valid_i, .rx_data_i, .rx_sof_i, .rx_eof_i, .rx_err_i,
		.fifo_vacant_i, .fifo_used_i, .byte_tick_i, .dma_valid_o,
		.dma_data_o, .dma_sof_o, .dma_eof_o, .dma_discard_o, .tx_pending_i,
		.tx_busy_i, .tx_allow_o, .gen_valid_o, .gen_data_o, .gen_sof_o,
		.gen_eof_o, .gen_ready_i, .wake_irq_o, .paused_o
	);
	mac_link_partner lp
	(
		.clock_i, .gen_valid_i(gen_valid_o), .gen_data_i(gen_data_o),
		.gen_ready_o(gen_ready_i), .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i), .rx_sof_o(rx_sof_i), .rx_eof_o(rx_eof_i),
		.rx_err_o(rx_err_i)
	);

	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// byte time every other cycle, so a quantum is 128 cycles
	always @(posedge clock_i)
	begin
		byte_tick_i <= ~byte_tick_i;
		irq_n <= irq_n + (wake_irq_o === 1'b1);
		disc_n <= disc_n + (dma_discard_o === 1'b1);
		dv_n <= dv_n + (dma_valid_o === 1'b1);
		eof_n <= eof_n + (dma_valid_o === 1'b1 && dma_eof_o === 1'b1);
		if (dma_valid_o === 1'b1 && dma_sof_o === 1'b1)
			dsof <= dma_data_o;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic [7:0] pbyte(input int i, input logic [47:0] s,
		input logic [15:0] t);
		logic [159:0] hd;
		hd = {48'h0180C2000001, s, 16'h8808, 16'h0001, t, 16'h0000};
		return (i < 18) ? hd[159 - 8 * i -: 8] : 8'h00;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			$display("[ERR] %0t got %h expected %h", $time, g, e);
			mismatches++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		chk(rdata_o, e);
	endtask

	task automatic rx_pause(input logic [15:0] t, input logic e);
		seed = xs(seed);
		for (int i = 0; i < 60; i++)
			lp.fr[i] = pbyte(i, {seed, 16'h0200}, t);
		lp.send(60, e);
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
	endtask

	task automatic magic(input logic [47:0] da, input int reps);
		for (int i = 0; i < 116; i++)
			lp.fr[i] = (i < 6) ? da[47 - 8 * i -: 8] : 8'hFF;
		{lp.fr[12], lp.fr[13]} = 16'h0800;
		for (int i = 20; i < 20 + 6 * reps; i++)
			lp.fr[i] = sa[47 - 8 * ((i - 20) % 6) -: 8];
		lp.send(116, 1'b0);
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
	endtask

	task automatic setaddr;
		wr(8'h04, {16'h0000, sa[47:32]});
		wr(8'h08, sa[31:0]);
	endtask

	task automatic waitcap(input int n);
		for (int k = 0; k < 600 && lp.ccount < n; k++)
			@(posedge clock_i);
		repeat (2) @(posedge clock_i);
	endtask

	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		{rst_i, wr_i, rd_i, byte_tick_i, tx_pending_i, tx_busy_i} = 6'h21;
		{addr_i, wdata_i} = 40'h00;
		ce_i = 1'b1;
		dsof = 8'h00;
		{mismatches, comparisons, irq_n, disc_n, dv_n, eof_n} = 192'h0;
		fifo_vacant_i = 11'h064;
		fifo_used_i = 11'h064;
		seed = 32'h00000024;
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		rdchk(8'h0C, 32'h00000000);
		rdchk(8'h14, 32'h00000000);
		rdchk(8'h00, 32'h00000040);
		rdchk(8'h1C, 32'h00000000);
		seed = xs(seed);
		sa[47:32] = seed[15:0];
		seed = xs(seed);
		sa[31:0] = seed;
		tv = seed[31:16] | 16'h0001;
		setaddr();
		wr(8'h0C, {16'h0000, tv});
		wr(8'h10, {16'h0010, 16'h0004});
		wr(8'h00, 32'h0000001E);
		rdchk(8'h0C, {16'h0000, tv});
		// clock enable low must swallow the write
		ce_i <= 1'b0;
		wr(8'h0C, {16'h0000, ~tv});
		ce_i <= 1'b1;
		rdchk(8'h0C, {16'h0000, tv});
		tx_pending_i <= 1'b1;
		rx_pause(16'h0002, 1'b0);
		chk(paused_o, 1);
		chk(tx_allow_o, 0);
		chk(disc_n, 1);
		repeat (200) @(posedge clock_i);
		chk(paused_o, 1);
		repeat (100) @(posedge clock_i);
		chk({paused_o, tx_allow_o}, 1);
		rx_pause(16'h00FF, 1'b1);
		chk(paused_o, 0);
		rx_pause(16'h00FF, 1'b0);
		rx_pause(16'h0000, 1'b0);
		chk(paused_o, 0);
		wr(8'h00, 32'h0000003E);
		dv0 = disc_n;
		rx_pause(16'h0000, 1'b0);
		chk(disc_n, dv0);
		chk(dsof, 8'h01);
		chk(eof_n, 5);
		tx_busy_i <= 1'b1;
		fifo_vacant_i <= 11'h008;
		for (int i = 0; i < 64; i++)
			lp.fr[i] = 8'(xs(seed + i));
		lp.send(64, 1'b0);
		fifo_vacant_i <= 11'h064;
		repeat (20) @(posedge clock_i);
		chk(lp.ccount, 0);
		tx_busy_i <= 1'b0;
		waitcap(60);
		for (int i = 0; i < 60; i++)
			chk(lp.cap[i], pbyte(i, sa, tv));
		fifo_used_i <= 11'h002;
		waitcap(120);
		for (int i = 0; i < 60; i++)
			chk(lp.cap[60 + i], pbyte(i, sa, 16'h0000));
		repeat (400) @(posedge clock_i);
		chk(lp.ccount, 120);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		setaddr();
		wr(8'h00, 32'h00000001);
		wr(8'h00, 32'h00000003);
		rdchk(8'h00, 32'h00000043);
		dv0 = dv_n;
		magic(sa, 16);
		chk(irq_n, 1);
		rdchk(8'h14, 32'h00000002);
		wr(8'h14, 32'h00000002);
		rdchk(8'h14, 32'h00000000);
		magic(48'hFFFFFFFFFFFF, 16);
		chk(irq_n, 2);
		magic(sa, 15);
		chk(irq_n, 2);
		chk(dv_n, dv0);
		chk(tx_allow_o, 0);
		end_sim();
	end

	initial
	begin
		repeat (50000) @(posedge clock_i);
		mismatches++;
		end_sim();
	end
endmodule
`default_nettype wire
